// [mbi_pkg.sv]
// constants and carrier types for the host bus interface front end
package mbi_pkg;
    // strap codes for the bus select pins
    localparam logic [3:0] MBI_STRAP_SERIAL = 4'h0;
    localparam logic [3:0] MBI_STRAP_P8_RW = 4'h4;
    localparam logic [3:0] MBI_STRAP_P16_RW = 4'h5;
    localparam logic [3:0] MBI_STRAP_P8_SEP = 4'h6;
    localparam logic [3:0] MBI_STRAP_P16_SEP = 4'h7;
    localparam logic [3:0] MBI_STRAP_P9_RW = 4'hC;
    localparam logic [3:0] MBI_STRAP_P18_RW = 4'hD;
    localparam logic [3:0] MBI_STRAP_P9_SEP = 4'hE;
    localparam logic [3:0] MBI_STRAP_P18_SEP = 4'hF;
    // field positions in the strap code
    localparam int MBI_STRAP_WIDE_BIT = 0;
    localparam int MBI_STRAP_SEP_BIT = 1;
    localparam int MBI_STRAP_PAR_BIT = 2;
    localparam int MBI_STRAP_NINE_BIT = 3;
    // bus geometry
    localparam int MBI_DATA_W = 18;
    localparam int MBI_SER_W = 8;
    localparam logic [2:0] MBI_SER_LAST = 3'h7;
    localparam logic [17:0] MBI_DATA_ZERO = 18'h00000;
    // remap command and the bit that enables odd/even common split
    localparam logic [7:0] MBI_CMD_REMAP = 8'hA0;
    localparam int MBI_SPLIT_BIT = 5;

    typedef enum logic [2:0] {
        MBI_MODE_SERIAL,
        MBI_MODE_RW_STROBE,
        MBI_MODE_SEP_STROBE,
        MBI_MODE_INVALID
    } mbi_mode_t;

    // host pin group as seen by the device
    typedef struct packed {
        logic chipSelN;
        logic dataCmd;
        logic rwWrN;
        logic enRdN;
        logic [17:0] data;
    } mbi_pins_t;

    // one accepted transfer
    typedef struct packed {
        logic isData;
        logic isRead;
        logic [17:0] word;
    } mbi_xfer_t;
endpackage : mbi_pkg

// [mbi_bus_interface.sv]
// host bus interface front end: strap decode, strobe decode, serial shifter
`timescale 1ns/1ps
module mbi_bus_interface (
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // straps and clock source
    input wire logic [3:0] bus_select_straps,
    input wire logic osc_source_sel,
    input wire logic external_timebase_in,
    input wire logic internalOsc,
    // host pins
    input wire logic chip_init_n,
    input wire mbi_pkg::mbi_pins_t hostPins,
    // spare inputs, ignored
    input wire logic [17:0] spare_pixel_bus,
    input wire logic spare_pixel_gate,
    input wire logic spare_dot_tick,
    // read return data
    input wire logic [17:0] readWord,
    // data bus drive
    output logic [17:0] dataOut,
    output logic [17:0] dataOe,
    // accepted transfers
    output mbi_pkg::mbi_xfer_t xfer,
    output logic xferValid,
    // decoded state
    output mbi_pkg::mbi_mode_t mode,
    output logic wideBus,
    output logic nineBus,
    output logic comSplit,
    output logic clockSel
);
    import mbi_pkg::*;

    // strap decode
    wire logic strapPar = bus_select_straps[MBI_STRAP_PAR_BIT];
    wire logic strapSep = bus_select_straps[MBI_STRAP_SEP_BIT];
    wire logic strapValid = (bus_select_straps == MBI_STRAP_SERIAL) || strapPar;
    mbi_mode_t modeNext;
    assign modeNext = !strapValid ? MBI_MODE_INVALID :
                      !strapPar ? MBI_MODE_SERIAL :
                      strapSep ? MBI_MODE_SEP_STROBE : MBI_MODE_RW_STROBE;

    // per-cycle strobe decode; the spare pins are deliberately not read
    logic enPrev_reg;
    logic wrPrev_reg;
    logic sclkPrev_reg;
    mbi_mode_t mode_reg;
    wire logic sel = !hostPins.chipSelN;
    wire logic isRwMode = (mode_reg == MBI_MODE_RW_STROBE);
    wire logic isSepMode = (mode_reg == MBI_MODE_SEP_STROBE);
    wire logic isSerMode = (mode_reg == MBI_MODE_SERIAL);
    wire logic enFall = enPrev_reg && !hostPins.enRdN;
    wire logic enRise = !enPrev_reg && hostPins.enRdN;
    wire logic wrRise = !wrPrev_reg && hostPins.rwWrN;
    // enable falling edge ends the transfer begun while enable was high
    wire logic rwLatch = isRwMode && sel && enFall;
    wire logic sepWrLatch = isSepMode && sel && wrRise;
    wire logic sepRdLatch = isSepMode && sel && enRise;
    // serial clock on data line 0, serial input on data line 1
    wire logic sclk = hostPins.data[0];
    wire logic serial_in_line = hostPins.data[1];
    wire logic sclkRise = isSerMode && sel && sclk && !sclkPrev_reg;
    // reads driven while selected and the read phase is active
    wire logic rwReadPhase = isRwMode && sel && hostPins.rwWrN && hostPins.enRdN;
    wire logic sepReadPhase = isSepMode && sel && !hostPins.enRdN;

    // serial shifter
    logic [7:0] shift_reg;
    logic [2:0] bitCnt_reg;
    wire logic [7:0] shiftNext = {shift_reg[6:0], serial_in_line};
    wire logic serByte = sclkRise && (bitCnt_reg == MBI_SER_LAST);

    // transfer assembly
    wire logic accept = rwLatch || sepWrLatch || sepRdLatch || serByte;
    wire logic acceptRead = (rwLatch && hostPins.rwWrN) || sepRdLatch;
    mbi_xfer_t xferNext;
    assign xferNext.isData = hostPins.dataCmd;
    assign xferNext.isRead = acceptRead;
    assign xferNext.word = serByte ? {10'h000, shiftNext} : hostPins.data;
    wire logic remapHit = accept && !acceptRead && !hostPins.dataCmd &&
                          (xferNext.word[7:0] == MBI_CMD_REMAP);
    logic remapPend_reg;
    wire logic paramHit = accept && !acceptRead && hostPins.dataCmd && remapPend_reg;

    // edge history and mode register; chip init acts like reset
    wire logic live = nrst && chip_init_n;
    always_ff @(posedge clock) begin
        if (!live) begin
            enPrev_reg <= 1'b0;
            wrPrev_reg <= 1'b1;
            sclkPrev_reg <= 1'b0;
            mode_reg <= MBI_MODE_INVALID;
        end else begin
            enPrev_reg <= hostPins.enRdN;
            wrPrev_reg <= hostPins.rwWrN;
            sclkPrev_reg <= sclk;
            mode_reg <= modeNext; // straps caught by clock after release
        end
    end

    // serial shift register; deselect restarts the byte
    always_ff @(posedge clock) begin
        if (!live || !sel) begin
            shift_reg <= 8'h00;
            bitCnt_reg <= 3'h0;
        end else if (sclkRise) begin
            shift_reg <= shiftNext;
            bitCnt_reg <= bitCnt_reg + 3'h1;
        end
    end

    // transfer outputs
    always_ff @(posedge clock) begin
        if (!live) begin
            xfer <= '0;
            xferValid <= 1'b0;
        end else begin
            xferValid <= accept;
            if (accept) begin
                xfer <= xferNext;
            end
        end
    end

    // remap tracking: command then parameter, bit 5 sets the split
    always_ff @(posedge clock) begin
        if (!live) begin
            remapPend_reg <= 1'b0;
            comSplit <= 1'b0;
        end else begin
            if (remapHit) begin
                remapPend_reg <= 1'b1;
            end else if (paramHit || (accept && !hostPins.dataCmd)) begin
                remapPend_reg <= 1'b0;
            end
            if (paramHit) begin
                comSplit <= xferNext.word[MBI_SPLIT_BIT];
            end
        end
    end

    // read drive; serial mode never drives, so data line 2 stays undriven
    always_ff @(posedge clock) begin
        if (!live) begin
            dataOut <= MBI_DATA_ZERO;
            dataOe <= MBI_DATA_ZERO;
        end else begin
            dataOut <= readWord;
            dataOe <= (rwReadPhase || sepReadPhase) ? {MBI_DATA_W{1'b1}} : MBI_DATA_ZERO;
        end
    end

    // decoded status; clock pick is a flag for the clock mux outside
    always_ff @(posedge clock) begin
        if (!live) begin
            mode <= MBI_MODE_INVALID;
            wideBus <= 1'b0;
            nineBus <= 1'b0;
            clockSel <= 1'b1;
        end else begin
            mode <= mode_reg;
            wideBus <= bus_select_straps[MBI_STRAP_WIDE_BIT] && strapPar;
            nineBus <= bus_select_straps[MBI_STRAP_NINE_BIT] && strapPar;
            clockSel <= osc_source_sel;
        end
    end

    // checks
    // properties watch the registered outputs one edge after the pins were sampled,
    // so most consequents use |=>, the $past checks on clockSel, dataOut and mode use |->; reset windows are skipped through the live term
    // except where the reset itself is the behaviour being checked
    sequence s_wrLow;
        isSepMode && sel && !hostPins.rwWrN;
    endsequence
    sequence s_wrHigh;
        isSepMode && sel && hostPins.rwWrN;
    endsequence
    AST_DESEL_NO_XFER: assert property (@(posedge clock) disable iff (!live)
        hostPins.chipSelN |=> !xferValid) else $error("transfer while deselected");
    AST_INVALID_IGNORED: assert property (@(posedge clock) disable iff (!live)
        (mode_reg == MBI_MODE_INVALID) |=> !xferValid) else $error("strobe taken in invalid mode");
    AST_DC_TYPE: assert property (@(posedge clock) disable iff (!live)
        accept |=> (xfer.isData == $past(hostPins.dataCmd))) else $error("data/command wrong");
    AST_RW_DIR: assert property (@(posedge clock) disable iff (!live)
        rwLatch |=> (xfer.isRead == $past(hostPins.rwWrN))) else $error("direction wrong");
    AST_RW_FALL: assert property (@(posedge clock) disable iff (!live)
        (isRwMode && sel && $fell(hostPins.enRdN) && $past(live)) |=> xferValid)
        else $error("enable fall missed");
    AST_SEP_WRITE: assert property (@(posedge clock) disable iff (!live)
        (s_wrLow ##1 s_wrHigh) |=> (xferValid && !xfer.isRead)) else $error("write missed");
    AST_SEP_READ_DRIVE: assert property (@(posedge clock) disable iff (!live)
        sepReadPhase |=> (dataOe == {MBI_DATA_W{1'b1}})) else $error("read not driven");
    AST_SER_BYTE: assert property (@(posedge clock) disable iff (!live)
        serByte |=> (xferValid && xfer.word[7:0] == $past(shiftNext))) else $error("serial byte");
    AST_CLK_SEL: assert property (@(posedge clock) disable iff (!live)
        $past(live) |-> (clockSel == $past(osc_source_sel))) else $error("clock select stale");
    AST_SER_NO_DRIVE: assert property (@(posedge clock) disable iff (!live)
        isSerMode |=> (dataOe == MBI_DATA_ZERO)) else $error("serial drove bus");

    // read strobe low then high, separate-strobe style
    sequence s_rdLow;
        isSepMode && sel && !hostPins.enRdN;
    endsequence
    sequence s_rdHigh;
        isSepMode && sel && hostPins.enRdN;
    endsequence

    // a read strobe rise yields a read transfer
    AST_SEP_READ: assert property (@(posedge clock) disable iff (!live)
        (s_rdLow ##1 s_rdHigh) |=> (xferValid && xfer.isRead)) else $error("read missed");

    // no enable fall, no transfer, in read-write-strobe style
    AST_RW_ENABLE_ONLY: assert property (@(posedge clock) disable iff (!live)
        (isRwMode && $past(live) && !$fell(hostPins.enRdN)) |=> !xferValid)
        else $error("transfer without enable fall");

    // read phase drives the whole bus
    AST_RW_READ_DRIVE: assert property (@(posedge clock) disable iff (!live)
        (isRwMode && sel && hostPins.rwWrN && hostPins.enRdN) |=> (dataOe == {MBI_DATA_W{1'b1}}))
        else $error("rw read not driven");

    // write direction never drives, avoids fighting the host
    AST_RW_WRITE_FLOAT: assert property (@(posedge clock) disable iff (!live)
        (isRwMode && !hostPins.rwWrN) |=> (dataOe == MBI_DATA_ZERO))
        else $error("bus driven on write");

    // deselected device leaves the bus alone
    AST_DESEL_FLOAT: assert property (@(posedge clock) disable iff (!live)
        hostPins.chipSelN |=> (dataOe == MBI_DATA_ZERO)) else $error("driven while deselected");

    // separate-strobe style with read strobe high stays off the bus
    AST_SEP_IDLE_FLOAT: assert property (@(posedge clock) disable iff (!live)
        (isSepMode && hostPins.enRdN) |=> (dataOe == MBI_DATA_ZERO))
        else $error("bus driven without read strobe");

    // invalid straps never drive the bus
    AST_INVALID_FLOAT: assert property (@(posedge clock) disable iff (!live)
        (mode_reg == MBI_MODE_INVALID) |=> (dataOe == MBI_DATA_ZERO))
        else $error("bus driven in invalid mode");

    // driven word is the read word of the cycle before
    AST_READ_DATA: assert property (@(posedge clock) disable iff (!live)
        (dataOe != MBI_DATA_ZERO) |-> (dataOut == $past(readWord)))
        else $error("read data stale");

    // init or reset clears transfers and the split, no disable here on purpose
    AST_INIT_CLEARS: assert property (@(posedge clock)
        !live |=> (!xferValid && !comSplit && mode == MBI_MODE_INVALID && clockSel))
        else $error("init did not clear state");

    // split only moves on a remap parameter
    AST_SPLIT_HOLD: assert property (@(posedge clock) disable iff (!live)
        !paramHit |=> $stable(comSplit)) else $error("split changed without parameter");

    // parameter with bit 5 set turns the split on
    AST_SPLIT_SET: assert property (@(posedge clock) disable iff (!live)
        (remapPend_reg && accept && !acceptRead && hostPins.dataCmd && xferNext.word[5])
        |=> comSplit) else $error("split not set");

    // a remap command arms the parameter capture
    AST_REMAP_PEND: assert property (@(posedge clock) disable iff (!live)
        remapHit |=> remapPend_reg) else $error("remap not armed");

    // any other command drops a pending remap
    AST_CMD_CANCEL: assert property (@(posedge clock) disable iff (!live)
        (accept && !acceptRead && !hostPins.dataCmd && xferNext.word[7:0] != MBI_CMD_REMAP)
        |=> !remapPend_reg) else $error("remap not cancelled");

    // each serial clock rise advances the bit count
    AST_SER_COUNT: assert property (@(posedge clock) disable iff (!live)
        sclkRise |=> (bitCnt_reg == $past(bitCnt_reg) + 3'h1)) else $error("bit count stuck");

    // serial style only writes
    AST_SER_ONLY_WRITES: assert property (@(posedge clock) disable iff (!live)
        isSerMode |=> !(xferValid && xfer.isRead)) else $error("serial read seen");

    // last transfer holds until the next one
    AST_XFER_HOLD: assert property (@(posedge clock) disable iff (!live)
        !accept |=> $stable(xfer)) else $error("transfer changed without accept");

    // width flags follow the strap bits in parallel styles only
    AST_WIDE_FLAG: assert property (@(posedge clock) disable iff (!live)
        (strapPar && bus_select_straps[MBI_STRAP_WIDE_BIT]) |=> wideBus)
        else $error("wide flag missing");
    AST_NINE_FLAG: assert property (@(posedge clock) disable iff (!live)
        (strapPar && bus_select_straps[MBI_STRAP_NINE_BIT]) |=> nineBus)
        else $error("nine flag missing");
    AST_SERIAL_NARROW: assert property (@(posedge clock) disable iff (!live)
        !strapPar |=> (!wideBus && !nineBus)) else $error("width flag in serial");

    // mode output trails the internal mode by one edge
    AST_MODE_FOLLOW: assert property (@(posedge clock) disable iff (!live)
        $past(live) |-> (mode == $past(mode_reg))) else $error("mode output stale");
endmodule : mbi_bus_interface

// [mbi_host_model.sv]
// host microcontroller model for the parallel and serial bus styles
`timescale 1ns/1ps
module mbi_host_model (
    // clock
    input wire logic clock,
    // pins toward the device and its read drive
    output mbi_pkg::mbi_pins_t pins,
    input wire logic [17:0] dataOut,
    input wire logic [17:0] dataOe
);
    import mbi_pkg::*;
    mbi_pins_t p;
    initial pins = {4'h8, MBI_DATA_ZERO};
    // pins change just after an edge and hold a whole cycle
    task automatic step;
        @(posedge clock);
        pins <= p;
    endtask : step
    // idle levels, unused data lines low
    task automatic idle(input logic sep);
        p = {1'b1, 1'b0, sep, sep, MBI_DATA_ZERO};
        step();
    endtask : idle
    // read-write-strobe cycle; on reads the host drives the inverse of the word
    task automatic rw_xfer(input logic csN, dc, rd, input logic [17:0] d);
        p = {csN, dc, rd, 1'b0, rd ? ~d : d};
        step();
        p.enRdN = 1'b1;
        step();
        p.enRdN = 1'b0;
        step();
        p.chipSelN = 1'b1;
        step();
    endtask : rw_xfer
    // separate-strobe cycle; read data taken before the strobe rises
    task automatic sep_xfer(input logic csN, dc, rd, input logic [17:0] d,
                            output logic [17:0] q);
        p = {csN, dc, 2'b11, rd ? ~d : d};
        step();
        if (rd) p.enRdN = 1'b0;
        else p.rwWrN = 1'b0;
        repeat (3) step();
        q = (dataOe === 18'h3FFFF) ? dataOut : ~dataOut;
        {p.rwWrN, p.enRdN} = 2'b11;
        step();
        p.chipSelN = 1'b1;
        step();
    endtask : sep_xfer
    // serial byte msb first; direction and read pins grounded
    task automatic ser_byte(input logic dc, input logic [7:0] b);
        p = {1'b0, dc, 2'b00, MBI_DATA_ZERO};
        for (int i = 7; i >= 0; i--) begin
            p.data[1:0] = {b[i], 1'b0};
            step();
            p.data[0] = 1'b1;
            step();
        end
        p.data[0] = 1'b0;
        step();
        p.chipSelN = 1'b1;
        p.data[1] = ~b[0];  // released line shows the inverse
        step();
    endtask : ser_byte
endmodule : mbi_host_model

// [tb_mbi_bus_interface.sv]
// self-checking bench for the host bus interface front end
`timescale 1ns/1ps
`define CHK(n, e, g) begin totalChecks++; if ((g) !== (e)) begin numErrors++; \
    $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module tb_mbi_bus_interface;
    import mbi_pkg::*;
    logic clock = 0, nrst = 0, oscSel = 1, initN = 1, xv, wide, nine, split, clkSel;
    logic [3:0] straps = 4'h0;
    logic [17:0] rdWord = 18'h2D5A3, dOut, dOe, q;
    logic [17:0] par[3] = '{18'h00060, 18'h00000, 18'h00060};
    mbi_pins_t pins;
    mbi_xfer_t xfer, lastX;
    mbi_mode_t mode;
    int numErrors = 0, totalChecks = 0, pulses = 0, cycles = 0, n0 = 0;
    // spare inputs and both unused clock inputs grounded
    mbi_bus_interface dut (.clock(clock), .nrst(nrst), .bus_select_straps(straps),
        .osc_source_sel(oscSel), .external_timebase_in(1'b0), .internalOsc(1'b0),
        .chip_init_n(initN), .hostPins(pins), .spare_pixel_bus(18'h00000),
        .spare_pixel_gate(1'b0), .spare_dot_tick(1'b0), .readWord(rdWord),
        .dataOut(dOut), .dataOe(dOe), .xfer(xfer), .xferValid(xv), .mode(mode),
        .wideBus(wide), .nineBus(nine), .comSplit(split), .clockSel(clkSel));
    mbi_host_model host (.clock(clock), .pins(pins), .dataOut(dOut), .dataOe(dOe));
    initial begin
        forever #2.5 clock = ~clock;
    end
    // pulse counter, non-blocking so readers never race it
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (xv === 1'b1) begin
            pulses <= pulses + 1;
            lastX <= xfer;
        end
        if (cycles == 5000) begin
            numErrors++;
            final_report();
        end
    end
    function automatic mbi_mode_t expMode(input logic [3:0] s);
        if (s == 4'h0) return MBI_MODE_SERIAL;
        if (!s[2]) return MBI_MODE_INVALID;
        return s[1] ? MBI_MODE_SEP_STROBE : MBI_MODE_RW_STROBE;
    endfunction : expMode
    task automatic reset_to(input logic [3:0] s, input int len);
        host.idle(s[2] & s[1]);
        straps <= s;
        nrst <= 1'b0;
        repeat (len) @(posedge clock);
        nrst <= 1'b1;
        repeat (4) @(posedge clock);
        n0 = pulses;
    endtask : reset_to
    // count of pulses since the last look, then the last transfer
    task automatic expect_x(input int cnt, input mbi_xfer_t e, input logic full);
        repeat (3) @(posedge clock);
        `CHK("pulses", cnt, pulses - n0)
        if (cnt > 0 && full) `CHK("xfer", e, lastX)
        else if (cnt > 0) `CHK("kind", e[19:18], lastX[19:18])
        n0 = pulses;
    endtask : expect_x
    task automatic final_report;
        $display("checks %0d errors %0d", totalChecks, numErrors);
        if (numErrors == 0 && totalChecks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : final_report
    initial begin
        reset_to(MBI_STRAP_SERIAL, 20);
        for (int s = 0; s < 16; s++) begin
            reset_to(s[3:0], 2);
            `CHK("mode", expMode(s[3:0]), mode)
            if (s[2]) `CHK("width", {s[3], s[0]}, {nine, wide})
        end
        reset_to(MBI_STRAP_SERIAL, 2);
        oscSel <= 1'b0;
        repeat (3) @(posedge clock);
        `CHK("clksel", 1'b0, clkSel)
        oscSel <= 1'b1;
        host.ser_byte(1'b1, 8'hA5);
        expect_x(1, {2'b10, 18'h000A5}, 1'b1);
        host.ser_byte(1'b0, 8'h3C);
        expect_x(1, {2'b00, 18'h0003C}, 1'b1);
        `CHK("clksel", 1'b1, clkSel)
        reset_to(4'h9, 2);
        host.sep_xfer(1'b0, 1'b1, 1'b0, 18'h00001, q);
        host.rw_xfer(1'b0, 1'b1, 1'b0, 18'h00001);
        expect_x(0, 20'h00000, 1'b0);
        reset_to(MBI_STRAP_P18_RW, 2);
        host.rw_xfer(1'b0, 1'b0, 1'b0, 18'h00015);
        host.rw_xfer(1'b0, 1'b1, 1'b0, 18'h3C3C3);
        expect_x(2, {2'b10, 18'h3C3C3}, 1'b1);
        host.rw_xfer(1'b1, 1'b1, 1'b0, 18'h11111);
        expect_x(0, 20'h00000, 1'b0);
        host.rw_xfer(1'b0, 1'b1, 1'b1, 18'h00000);  // dummy read first
        host.rw_xfer(1'b0, 1'b1, 1'b1, 18'h00000);
        expect_x(2, {2'b11, 18'h00000}, 1'b0);
        reset_to(MBI_STRAP_P18_SEP, 2);
        host.sep_xfer(1'b0, 1'b1, 1'b1, 18'h00000, q);
        expect_x(1, {2'b11, 18'h00000}, 1'b0);
        `CHK("rdata", rdWord, q)
        host.sep_xfer(1'b1, 1'b1, 1'b0, 18'h22222, q);
        expect_x(0, 20'h00000, 1'b0);
        // remap parameter: bit 5 sets the split, a zero parameter clears it
        foreach (par[i]) begin
            host.sep_xfer(1'b0, 1'b0, 1'b0, 18'h000A0, q);
            host.sep_xfer(1'b0, 1'b1, 1'b0, par[i], q);
            expect_x(2, {2'b10, par[i]}, 1'b1);
            `CHK("split", par[i][5], split)
        end
        initN <= 1'b0;
        @(posedge clock);
        initN <= 1'b1;
        repeat (4) @(posedge clock);
        `CHK("split", 1'b0, split)
        `CHK("xfer", 20'h00000, xfer)
        final_report();
    end
endmodule : tb_mbi_bus_interface
